// *** rtl/tdcw_engine.sv ***
/*
 * Transmit descriptor control-word engine. Takes word 0 of each fetched
 * descriptor, drives the frame options to the transmit path, picks the next
 * descriptor address and writes word 0 back with ownership returned.
 * Assumes the fetch logic, transmit path and register master all run on
 * sys_clk, so no input is synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Bit 31 gives ownership; device clears it on write-back after buffers or frame.
// - Interrupt-on-completion raises transmit-done status after the frame is sent.
// - Last segment needs a non-zero buffer size; zero sizes flag an error.
// - Frame options are taken only from first-segment descriptors.
// - CRC disable in first segment stops CRC append.
// - Pad disable stops padding of short frames.
// - Pad disable clear forces padding and CRC, overriding CRC disable.
// - Timestamp enable requests a hardware timestamp for the frame.
// - Two-bit checksum control picks insertion mode, first segment only.
// - Codes: off, header only, header and payload, plus hardware pseudoheader.
// - End-of-ring sends the next fetch back to the list base.
// - Chained uses the second address as next pointer, second size ignored.
// - Timestamp status set on last-segment write-back when a timestamp was taken.
module tdcw_engine
   import tdcw_pkg::*;
(
   input  wire logic        sys_clk,             // System clock, 10 MHz
   input  wire logic        rst_n,               // Sync reset, active low
   input  wire logic        clk_en,              // Freezes all state when low
   input  wire logic [7:0]  reg_addr,            // Register byte address
   input  wire logic [31:0] reg_wdata,           // Register write data
   input  wire logic        reg_wr,              // Write strobe
   input  wire logic        reg_rd,              // Read strobe
   output logic      [31:0] reg_rdata,           // Read data, next cycle
   input  wire logic        desc_valid,          // Fetched descriptor present
   input  wire logic [31:0] desc_addr,           // Address of that descriptor
   input  wire logic [31:0] tx_desc_word0,       // Control word
   input  wire logic [31:0] tx_desc_word1,       // Buffer sizes word
   input  wire logic [31:0] desc_addr2,          // Second address word
   input  wire logic        buf_done,            // All buffers read
   input  wire logic        frame_done,          // Frame transmitted
   input  wire logic        ts_captured,         // Timestamp taken by MAC
   output logic             desc_ready,          // Engine can take a word
   output logic      [31:0] next_desc_addr,      // Next fetch address
   output logic      [12:0] buffer1_size,        // First buffer size
   output logic      [12:0] buffer2_size,        // Second size, 0 if chained
   output logic             crc_append,          // Append FCS
   output logic             pad_enable,          // Pad short frames
   output logic             tx_timestamp_req,    // Capture timestamp
   output logic             csum_hdr_en,         // Insert IP header sum
   output logic             csum_payload_en,     // Insert payload sum
   output logic             csum_pseudo_hw,      // Pseudoheader by hardware
   output logic             wb_valid,            // Write-back pulse
   output logic      [31:0] wb_word0,            // Word 0 to write back
   output logic             irq                  // Level interrupt
);

   tdcw_state_e       state;
   logic              eng_enable;
   logic [31:0]       list_base;
   logic [ST_W-1:0]   irq_mask;
   logic [ST_W-1:0]   status_q;
   logic [ST_W-1:0]   status_set;
   logic [31:0]       cur_w0;
   logic [1:0]        csum_mode;
   logic              ts_seen;
   logic              accept;
   logic              unowned;
   logic              len_bad;
   logic              stat_rd;
   logic              wb_now;
   logic              wb_last;
   logic [31:0]       next_wb;

   // A descriptor is taken only while idle, enabled and owned by the DMA
   assign accept  = clk_en && desc_valid && state == S_IDLE && eng_enable
                    && tx_desc_word0[OWN_BIT];
   // Host-owned word seen: software has not handed it over yet
   assign unowned = clk_en && desc_valid && state == S_IDLE && eng_enable
                    && !tx_desc_word0[OWN_BIT];
   // Last segment must carry a size; buffer 2 counts only when not chained
   assign len_bad = tx_desc_word0[LS_BIT]
                    && tx_desc_word1[BUF1_HI:BUF1_LO] == '0
                    && (tx_desc_word0[CHN_BIT]
                        || tx_desc_word1[BUF2_HI:BUF2_LO] == '0);
   assign stat_rd = clk_en && reg_rd && reg_addr == REG_STATUS;

   // Write-back moments: buffers read on a middle segment, or frame sent
   assign wb_now  = clk_en && ((state == S_BUFS && buf_done && !cur_w0[LS_BIT])
                    || (state == S_XMIT && frame_done));
   assign wb_last = state == S_XMIT;
   assign next_wb = {1'b0, cur_w0[30:18], wb_last && ts_seen, cur_w0[16:0]};

   // Event pulses into the sticky status bits
   always_comb begin
      status_set             = '0;
      status_set[ST_TX_DONE] = wb_now && wb_last && cur_w0[IOC_BIT];
      status_set[ST_LEN_ERR] = accept && len_bad;
      status_set[ST_TS_DONE] = wb_now && wb_last && ts_seen;
      status_set[ST_UNOWNED] = unowned;
   end

   tdcw_sticky #(
      .W (ST_W)
   ) u_status (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .set     (status_set),
      .clr     (stat_rd),
      .q       (status_q)
   );

   tdcw_next_addr u_next (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .load      (accept),
      .ring_end  (tx_desc_word0[EOR_BIT]),
      .chained   (tx_desc_word0[CHN_BIT]),
      .cur_addr  (desc_addr),
      .addr2     (desc_addr2),
      .base      (list_base),
      .next_addr (next_desc_addr)
   );

   // Descriptor sequencing: buffers first, then on a last segment wait for the frame end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state  <= S_IDLE;
         cur_w0 <= WORD_RST;
      end else if (clk_en) begin
         unique case (state)
            S_IDLE: begin
               if (accept) begin
                  state  <= S_BUFS;
                  cur_w0 <= tx_desc_word0;
               end
            end
            S_BUFS: begin
               if (buf_done) begin
                  state <= cur_w0[LS_BIT] ? S_XMIT : S_IDLE;
               end
            end
            S_XMIT: begin
               if (frame_done) begin
                  state <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Ready is a flop so the fetch side sees a clean level
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         desc_ready <= 1'b0;
      end else if (clk_en) begin
         desc_ready <= eng_enable && ((state == S_IDLE && !accept) || wb_now);
      end
   end

   // Buffer sizes; second size is meaningless once chained
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         buffer1_size <= '0;
         buffer2_size <= '0;
      end else if (accept) begin
         buffer1_size <= tx_desc_word1[BUF1_HI:BUF1_LO];
         buffer2_size <= tx_desc_word0[CHN_BIT] ? '0 : tx_desc_word1[BUF2_HI:BUF2_LO];
      end
   end

   // Frame options latch only on a first segment; later segments inherit
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         crc_append       <= 1'b1;
         pad_enable       <= 1'b1;
         tx_timestamp_req <= 1'b0;
         csum_mode        <= CSUM_OFF;
      end else if (accept && tx_desc_word0[FS_BIT]) begin
         pad_enable       <= !tx_desc_word0[DP_BIT];
         // Padding needs a fresh CRC, so CRC disable only counts without pad
         crc_append       <= !tx_desc_word0[DC_BIT] || !tx_desc_word0[DP_BIT];
         tx_timestamp_req <= tx_desc_word0[TSE_BIT];
         csum_mode        <= tx_desc_word0[CIC_HI:CIC_LO];
      end
   end

   // Checksum mode decoded to the three insertion controls
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         csum_hdr_en     <= 1'b0;
         csum_payload_en <= 1'b0;
         csum_pseudo_hw  <= 1'b0;
      end else if (clk_en) begin
         unique case (tdcw_csum_e'(csum_mode))
            CSUM_OFF: begin
               csum_hdr_en     <= 1'b0;
               csum_payload_en <= 1'b0;
               csum_pseudo_hw  <= 1'b0;
            end
            CSUM_HDR: begin
               csum_hdr_en     <= 1'b1;
               csum_payload_en <= 1'b0;
               csum_pseudo_hw  <= 1'b0;
            end
            CSUM_NO_PSH: begin
               csum_hdr_en     <= 1'b1;
               csum_payload_en <= 1'b1;
               csum_pseudo_hw  <= 1'b0;
            end
            CSUM_FULL: begin
               csum_hdr_en     <= 1'b1;
               csum_payload_en <= 1'b1;
               csum_pseudo_hw  <= 1'b1;
            end
         endcase
      end
   end

   // Timestamp seen during a stamped frame; fresh frame starts clean
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ts_seen <= 1'b0;
      end else if (clk_en) begin
         if (accept && tx_desc_word0[FS_BIT]) begin
            ts_seen <= 1'b0;
         end else if (ts_captured && tx_timestamp_req && state != S_IDLE) begin
            ts_seen <= 1'b1;
         end
      end
   end

   // Write-back word and its one-cycle strobe
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wb_valid <= 1'b0;
         wb_word0 <= WORD_RST;
      end else if (clk_en) begin
         wb_valid <= wb_now;
         if (wb_now) begin
            wb_word0 <= next_wb;
         end
      end
   end

   // Software-written registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         eng_enable <= CTRL_RST;
         list_base  <= BASE_RST;
         irq_mask   <= MASK_RST;
      end else if (clk_en && reg_wr) begin
         unique case (reg_addr)
            REG_CTRL: eng_enable <= reg_wdata[0];
            REG_BASE: list_base  <= reg_wdata;
            REG_MASK: irq_mask   <= reg_wdata[ST_W-1:0];
            default:  ;
         endcase
      end
   end

   // Read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               REG_CTRL:   reg_rdata <= {30'h0000_0000, state != S_IDLE, eng_enable};
               REG_BASE:   reg_rdata <= list_base;
               REG_STATUS: reg_rdata <= {28'h000_0000, status_q};
               REG_MASK:   reg_rdata <= {28'h000_0000, irq_mask};
               REG_WBACK:  reg_rdata <= wb_word0;
               REG_OPTS:   reg_rdata <= {24'h00_0000, csum_mode, ts_seen, tx_timestamp_req,
                                         pad_enable, crc_append, state};
               default:    reg_rdata <= '0;
            endcase
         end
      end
   end

   // Interrupt level; one cycle behind the status bits by design
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(status_q & irq_mask);
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_wb_owner_clear: assert property (wb_valid |-> !wb_word0[OWN_BIT])
      else $error("write-back keeps owner bit set");

   a_irq_on_done: assert property (clk_en && state == S_XMIT && frame_done && cur_w0[IOC_BIT]
                                   |=> status_q[ST_TX_DONE])
      else $error("transmit done status not set");

   a_len_error: assert property (accept && len_bad |=> status_q[ST_LEN_ERR])
      else $error("empty last segment not flagged");

   a_fs_option_gate: assert property (accept && !tx_desc_word0[FS_BIT]
                                      |=> $stable(pad_enable) && $stable(csum_mode)
                                          && $stable(tx_timestamp_req))
      else $error("options changed on a middle segment");

   a_crc_pad_rule: assert property (accept && tx_desc_word0[FS_BIT] && tx_desc_word0[DC_BIT]
                                    && tx_desc_word0[DP_BIT] |=> !crc_append && !pad_enable)
      else $error("crc or pad not disabled");

   a_pad_forces_crc: assert property (pad_enable |-> crc_append)
      else $error("padding without crc");

   a_ts_request: assert property (accept && tx_desc_word0[FS_BIT]
                                  |=> tx_timestamp_req == $past(tx_desc_word0[TSE_BIT]))
      else $error("timestamp request not taken");

   a_csum_decode: assert property (csum_mode == CSUM_FULL && clk_en
                                   |=> csum_pseudo_hw && csum_payload_en && csum_hdr_en)
      else $error("checksum mode decode wrong");

   a_ring_wrap: assert property (accept && tx_desc_word0[EOR_BIT]
                                 |=> next_desc_addr == $past(list_base))
      else $error("end of ring did not wrap");

   a_chain_size: assert property (accept && tx_desc_word0[CHN_BIT] && !tx_desc_word0[EOR_BIT]
                                  |=> buffer2_size == '0 && next_desc_addr == $past(desc_addr2))
      else $error("chain not followed");

   a_ts_status: assert property (wb_valid && wb_word0[TX_TIMESTAMP_STATUS_BIT] |-> wb_word0[LS_BIT])
      else $error("timestamp status on non-last segment");

endmodule
`default_nettype wire

// *** rtl/tdcw_pkg.sv ***
/*
 * Constants for the transmit descriptor control-word engine: word-0 and
 * word-1 field positions, register offsets, reset values, state and
 * checksum-mode encodings.
 * Assumes 32-bit descriptor words and a byte-addressed register port.
 */
package tdcw_pkg;

   // Word-0 control and status field positions
   localparam int OWN_BIT  = 31;
   localparam int IOC_BIT  = 30;
   localparam int LS_BIT   = 29;
   localparam int FS_BIT   = 28;
   localparam int DC_BIT   = 27;
   localparam int DP_BIT   = 26;
   localparam int TSE_BIT  = 25;
   localparam int CIC_HI   = 23;
   localparam int CIC_LO   = 22;
   localparam int EOR_BIT  = 21;
   localparam int CHN_BIT  = 20;
   localparam int TX_TIMESTAMP_STATUS_BIT = 17;

   // Word-1 buffer size fields
   localparam int BUF2_HI = 28;
   localparam int BUF2_LO = 16;
   localparam int BUF1_HI = 12;
   localparam int BUF1_LO = 0;
   localparam int SIZE_W  = 13;

   // Byte distance between consecutive descriptors (eight words)
   localparam logic [31:0] DESC_STEP = 32'h0000_0020;

   // Register offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_BASE   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_MASK   = 8'h0C;
   localparam logic [7:0] REG_WBACK  = 8'h10;
   localparam logic [7:0] REG_OPTS   = 8'h14;

   // Status and mask bit positions
   localparam int ST_TX_DONE = 0;
   localparam int ST_LEN_ERR = 1;
   localparam int ST_TS_DONE = 2;
   localparam int ST_UNOWNED = 3;
   localparam int ST_W       = 4;

   // Reset values
   localparam logic        CTRL_RST  = 1'b0;
   localparam logic [31:0] BASE_RST  = 32'h0000_0000;
   localparam logic [3:0]  MASK_RST  = 4'h0;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;
   localparam logic [3:0]  STAT_RST  = 4'h0;

   typedef enum logic [1:0] {
      CSUM_OFF     = 2'b00,
      CSUM_HDR     = 2'b01,
      CSUM_NO_PSH  = 2'b10,
      CSUM_FULL    = 2'b11
   } tdcw_csum_e;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_BUFS = 2'b01,
      S_XMIT = 2'b10
   } tdcw_state_e;

endpackage

// *** rtl/tdcw_sticky.sv ***
/*
 * Sticky event bits with clear-on-read.
 * Assumes set and clear pulses come from logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tdcw_sticky
   import tdcw_pkg::*;
#(
   parameter int W = 4
) (
   input  wire logic         sys_clk, // System clock
   input  wire logic         rst_n,   // Sync reset, active low
   input  wire logic         clk_en,  // Freezes state when low
   input  wire logic [W-1:0] set,     // Event pulses
   input  wire logic         clr,     // Read of the register
   output logic      [W-1:0] q        // Sticky bits
);

   // A set in the clearing cycle survives, so no event is lost
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (clk_en) begin
         q <= (q & ~{W{clr}}) | set;
      end
   end

endmodule
`default_nettype wire

// *** rtl/tdcw_next_addr.sv ***
/*
 * Next descriptor address selection: ring wrap, chain or step.
 * Assumes load is a one-cycle pulse on sys_clk beside the inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module tdcw_next_addr
   import tdcw_pkg::*;
(
   input  wire logic        sys_clk,   // System clock
   input  wire logic        rst_n,     // Sync reset, active low
   input  wire logic        clk_en,    // Freezes state when low
   input  wire logic        load,      // Descriptor accepted
   input  wire logic        ring_end,  // End-of-ring flag
   input  wire logic        chained,   // Second address is next pointer
   input  wire logic [31:0] cur_addr,  // This descriptor's address
   input  wire logic [31:0] addr2,     // Second address word
   input  wire logic [31:0] base,      // List base address
   output logic      [31:0] next_addr  // Where to fetch next
);

   // Ring end beats chaining so a chained ring still wraps
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         next_addr <= BASE_RST;
      end else if (clk_en && load) begin
         if (ring_end) begin
            next_addr <= base;
         end else if (chained) begin
            next_addr <= addr2;
         end else begin
            next_addr <= cur_addr + DESC_STEP;
         end
      end
   end

endmodule
`default_nettype wire

// *** tb/tdcw_fetch_model.sv ***
/*
 * Model of the fetch logic and transmit path beside the control-word engine.
 * Assumes the bench calls send() from one process, one descriptor at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module tdcw_fetch_model
   import tdcw_pkg::*;
(
   input  wire logic        sys_clk,       // System clock
   input  wire logic        desc_ready,    // Engine can take a word
   output logic             desc_valid,    // Descriptor present
   output logic      [31:0] desc_addr,     // Its address
   output logic      [31:0] tx_desc_word0, // Control word
   output logic      [31:0] tx_desc_word1, // Sizes word
   output logic      [31:0] desc_addr2,    // Second address
   output logic             buf_done,      // Buffers read
   output logic             frame_done,    // Frame sent
   output logic             ts_captured    // Timestamp taken
);
   // Quiet link at time zero
   initial begin
      {desc_valid, buf_done, frame_done, ts_captured} = 4'h0;
      {desc_addr, tx_desc_word0, tx_desc_word1, desc_addr2} = '0;
   end

   // Present one descriptor; if owned, play the buffer reads, then the frame on a last segment
   task automatic send(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] a,
                       input logic [31:0] a2, input logic ts, input int gap);
      int n;
      n = 0;
      while (desc_ready !== 1'b1 && n < 50) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      // All words land at once, owner bit with them
      @(posedge sys_clk);
      desc_valid <= 1'b1;
      desc_addr <= a;
      tx_desc_word0 <= w0;
      tx_desc_word1 <= w1;
      desc_addr2 <= a2;
      @(posedge sys_clk);
      desc_valid <= 1'b0;
      // Released lines flip so a late sample cannot pass
      desc_addr <= ~a;
      tx_desc_word0 <= ~w0;
      tx_desc_word1 <= ~w1;
      desc_addr2 <= ~a2;
      if (w0[31] === 1'b1) begin
         repeat (gap) @(posedge sys_clk);
         buf_done <= 1'b1;
         @(posedge sys_clk);
         buf_done <= 1'b0;
         if (w0[29] === 1'b1) begin
            @(posedge sys_clk);
            ts_captured <= ts;
            @(posedge sys_clk);
            ts_captured <= 1'b0;
            frame_done <= 1'b1;
            @(posedge sys_clk);
            frame_done <= 1'b0;
         end
      end
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 * Self-checking bench for the control-word engine: register tasks, a fetch
 * model and short descriptor sequences with worked-out expectations.
 * Assumes a single 10 MHz clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tdcw_pkg::*;
   logic        sys_clk, rst_n, clk_en, reg_wr, reg_rd, desc_valid, buf_done, frame_done, ts_captured;
   logic        desc_ready, crc_append, pad_enable, tx_timestamp_req, wb_valid, irq;
   logic        csum_hdr_en, csum_payload_en, csum_pseudo_hw;
   logic [7:0]  reg_addr;
   logic [12:0] buffer1_size, buffer2_size;
   logic [31:0] reg_wdata, reg_rdata, desc_addr, tx_desc_word0, tx_desc_word1, desc_addr2;
   logic [31:0] next_desc_addr, wb_word0, wb_seen, w0, a, exp_next;
   int          err_total, total_checks, wb_count;

   // 100 ns period
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;

   tdcw_engine dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .desc_valid(desc_valid), .desc_addr(desc_addr), .tx_desc_word0(tx_desc_word0),
      .tx_desc_word1(tx_desc_word1), .desc_addr2(desc_addr2), .buf_done(buf_done),
      .frame_done(frame_done), .ts_captured(ts_captured), .desc_ready(desc_ready),
      .next_desc_addr(next_desc_addr), .buffer1_size(buffer1_size), .buffer2_size(buffer2_size),
      .crc_append(crc_append), .pad_enable(pad_enable), .tx_timestamp_req(tx_timestamp_req),
      .csum_hdr_en(csum_hdr_en), .csum_payload_en(csum_payload_en), .csum_pseudo_hw(csum_pseudo_hw),
      .wb_valid(wb_valid), .wb_word0(wb_word0), .irq(irq));

   tdcw_fetch_model fetch_u (.sys_clk(sys_clk), .desc_ready(desc_ready), .desc_valid(desc_valid),
      .desc_addr(desc_addr), .tx_desc_word0(tx_desc_word0), .tx_desc_word1(tx_desc_word1),
      .desc_addr2(desc_addr2), .buf_done(buf_done), .frame_done(frame_done),
      .ts_captured(ts_captured));

   // Count write-backs and keep the last word; one pulse per owned descriptor, none for host-owned
   always @(posedge sys_clk) begin
      if (wb_valid === 1'b1) begin
         wb_seen <= wb_word0;
         wb_count <= wb_count + 1;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic end_sim;
      $display("TB: checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog well past the hundred or so cycles the tests need
   initial begin
      #3_000_000;
      err_total++;
      end_sim();
   end

   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      clk_en = 1'b1;
      {err_total, total_checks, wb_count, wb_seen} = '0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      // Reset state, unmapped and read-only places
      chk({desc_ready, crc_append, pad_enable, irq}, 32'h0000_0006);
      rd_chk(REG_CTRL, 32'h0000_0000);
      rd_chk(REG_MASK, 32'h0000_0000);
      wr(8'h40, 32'hFFFF_FFFF);
      rd_chk(8'h40, 32'h0000_0000);
      wr(REG_STATUS, 32'h0000_000F);
      rd_chk(REG_STATUS, 32'h0000_0000);
      wr(REG_BASE, 32'h0000_1000);
      rd_chk(REG_BASE, 32'h0000_1000);
      wr(REG_MASK, 32'h0000_000F);
      wr(REG_CTRL, 32'h0000_0001);
      $display("TEST registers: done");

      // Single-segment stamped frame, pad on so CRC forced despite its disable bit
      w0 = 32'hFAC0_0000;
      fetch_u.send(w0, 32'h0010_0040, 32'h0000_2000, 32'h0000_3000, 1'b1, 3);
      settle();
      chk(next_desc_addr, 32'h0000_2000 + DESC_STEP);
      chk({buffer2_size, buffer1_size}, {13'h0010, 13'h0040});
      chk({crc_append, pad_enable}, 32'h0000_0003);
      chk(tx_timestamp_req, 32'h0000_0001);
      chk({csum_hdr_en, csum_payload_en, csum_pseudo_hw}, 32'h0000_0007);
      chk(wb_count, 32'h0000_0001);
      chk(wb_seen, 32'h7AC2_0000);
      chk(irq, 32'h0000_0001);
      rd_chk(REG_STATUS, 32'h0000_0005);
      chk(desc_ready, 32'h0000_0001);
      rd_chk(REG_WBACK, 32'h7AC2_0000);
      rd_chk(REG_OPTS, 32'h0000_00FC);
      settle();
      chk(irq, 32'h0000_0000);
      $display("TEST stamped frame: done");

      // Every checksum code with ring and chain combinations
      for (int i = 0; i < 4; i++) begin
         w0 = 32'h9C00_0000 | (i << 22) | ((i & 1) << 21) | ((i >> 1) << 20);
         a = 32'h0000_4000 + i * 32'h0000_0100;
         exp_next = (i & 1) ? 32'h0000_1000 : ((i >> 1) ? a + 32'h0000_4000 : a + DESC_STEP);
         fetch_u.send(w0, 32'h0020_0030, a, a + 32'h0000_4000, 1'b0, 1);
         settle();
         chk(next_desc_addr, exp_next);
         chk(buffer2_size, (i >> 1) ? 13'h0000 : 13'h0020);
         chk({crc_append, pad_enable, tx_timestamp_req}, 32'h0000_0000);
         chk({csum_hdr_en, csum_payload_en, csum_pseudo_hw}, {i != 0, i >= 2, i == 3});
         chk(wb_count, i + 2);
      end
      $display("TEST checksum and ring: done");

      // Later segment: options must stay, zero sizes flagged, no stamp bit
      rd_chk(REG_STATUS, 32'h0000_0000);
      fetch_u.send(32'hA200_0000, 32'h0000_0000, 32'h0000_6000, 32'h0000_7000, 1'b1, 2);
      settle();
      chk({crc_append, pad_enable, tx_timestamp_req}, 32'h0000_0000);
      chk({csum_hdr_en, csum_payload_en, csum_pseudo_hw}, 32'h0000_0007);
      chk(wb_seen, 32'h2200_0000);
      rd_chk(REG_STATUS, 32'h0000_0001 << ST_LEN_ERR);
      $display("TEST later segment: done");

      // Host-owned descriptor with the interrupt masked off
      wr(REG_MASK, 32'h0000_0000);
      fetch_u.send(32'h1000_0000, 32'h0000_0040, 32'h0000_8000, 32'h0000_9000, 1'b0, 1);
      settle();
      chk(irq, 32'h0000_0000);
      chk(wb_count, 32'h0000_0006);
      rd_chk(REG_STATUS, 32'h0000_0001 << ST_UNOWNED);
      $display("TEST host owned: done");

      // Clock enable low: a write must not land while frozen
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(REG_MASK, 32'h0000_000F);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd_chk(REG_MASK, 32'h0000_0000);
      $display("TEST clock enable: done");
      end_sim();
   end
endmodule
`default_nettype wire
